//--- common/arfq_pkg.sv
// Shared constants and carrier types for the read-address channel FIFO
`default_nettype none
package arfq_pkg;
  // ****************************************************
  // Widths and sizes
  // ****************************************************
  localparam int ADDR_W = 32;
  localparam int PROT_W = 4;
  localparam int ENTRY_W = ADDR_W + PROT_W;
  localparam int PAR_W = 6;
  localparam int CODE_W = ENTRY_W + PAR_W + 1;
  localparam int FIFO_DEPTH = 8;
  // ****************************************************
  // Error injection bit positions inside a codeword
  // ****************************************************
  localparam int INJ_POS_A = 3;
  localparam int INJ_POS_B = 5;
  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic RST_FLAG = 1'h0;
  localparam logic RST_RUN = 1'h0;
  // Address word and protection bits as one stored entry
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [PROT_W-1:0] prot;
  } arfq_entry_s;
  // Decoder result travelling with an entry
  typedef struct packed {
    arfq_entry_s entry;
    logic single_err;
    logic double_err;
  } arfq_dec_s;
endpackage : arfq_pkg
`default_nettype wire

//--- logic/arfq_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count
`default_nettype none
module arfq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Filling side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Draining side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out,
  // Stored word count
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic wr_fire;
  logic rd_fire;
  // Honest full and empty
  assign wr_ready_out = (count_ff != CW'(DEPTH));
  assign rd_valid_out = (count_ff != '0);
  assign wr_fire = wr_valid_in & wr_ready_out;
  assign rd_fire = rd_valid_out & rd_ready_in;
  assign rd_data_out = mem_ff[rd_ptr_ff];
  assign count_out = count_ff;
  // Pointer wrap at the end of storage
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction : bump
  // Storage array
  always_ff @(posedge clk_in)
  begin
    if (wr_fire)
    begin
      mem_ff[wr_ptr_ff] <= wr_data_in;
    end
  end
  // Pointers and count
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (wr_fire)
      begin
        wr_ptr_ff <= bump(wr_ptr_ff);
      end
      if (rd_fire)
      begin
        rd_ptr_ff <= bump(rd_ptr_ff);
      end
      if (wr_fire && !rd_fire)
      begin
        count_ff <= count_ff + CW'(1);
      end
      else if (rd_fire && !wr_fire)
      begin
        count_ff <= count_ff - CW'(1);
      end
    end
  end
endmodule : arfq_fifo
`default_nettype wire

//--- logic/arfq_ecc_dec.sv
// SECDED decoder that corrects one flipped bit and flags two
`default_nettype none
module arfq_ecc_dec (
  // Stored codeword
  input wire logic [arfq_pkg::CODE_W-1:0] code_in,
  // Corrected entry and error flags
  output arfq_pkg::arfq_dec_s dec_out
);
  localparam int NPOS = arfq_pkg::CODE_W - 1;
  // Syndrome, correction and data extraction
  always_comb
  begin
    logic [arfq_pkg::PAR_W-1:0] syn;
    logic [arfq_pkg::CODE_W-1:0] fixed;
    logic [arfq_pkg::ENTRY_W-1:0] data;
    logic odd;
    int j;
    syn = '0;
    fixed = code_in;
    data = '0;
    odd = ^code_in;
    j = 0;
    for (int p = 1; p <= NPOS; p++)
    begin
      for (int i = 0; i < arfq_pkg::PAR_W; i++)
      begin
        if (((p >> i) & 1) == 1)
        begin
          syn[i] = syn[i] ^ code_in[p];
        end
      end
    end
    if (odd && (int'(syn) <= NPOS))
    begin
      fixed[syn] = ~fixed[syn];
    end
    for (int p = 1; p <= NPOS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        data[j] = fixed[p];
        j = j + 1;
      end
    end
    dec_out.entry = data;
    dec_out.single_err = odd;
    dec_out.double_err = !odd && (syn != '0);
  end
endmodule : arfq_ecc_dec
`default_nettype wire

//--- logic/arfq_top.sv
// Read-address channel FIFO between an upstream master and a downstream slave
`default_nettype none
// ****************************************************
// Read-address channel FIFO
// ****************************************************
module arfq_top #(
  parameter int DEPTH = arfq_pkg::FIFO_DEPTH,
  parameter logic ECC_EN = 1'h1
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Slave side, from the upstream master
  input wire logic [arfq_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic [arfq_pkg::PROT_W-1:0] S_AXI_ARPROT_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  // Master side, toward the downstream slave
  output logic [arfq_pkg::ADDR_W-1:0] M_AXI_ARADDR_OUT,
  output logic [arfq_pkg::PROT_W-1:0] M_AXI_ARPROT_OUT,
  output logic M_AXI_ARVALID_OUT,
  input wire logic M_AXI_ARREADY_IN,
  // Programmable thresholds
  input wire logic [$clog2(DEPTH)-1:0] AR_FULL_THRESHOLD_IN,
  input wire logic [$clog2(DEPTH)-1:0] AR_EMPTY_THRESHOLD_IN,
  // Error injection
  input wire logic AR_INJECT_SINGLE_ERROR_IN,
  input wire logic AR_INJECT_DOUBLE_ERROR_IN,
  // Status
  output logic AR_SINGLE_ERROR_FLAG_OUT,
  output logic AR_DOUBLE_ERROR_FLAG_OUT,
  output logic AR_WRITE_REJECTED_FLAG_OUT,
  output logic AR_PROG_FULL_OUT,
  output logic AR_PROG_EMPTY_OUT
);
  // ****************************************************
  // Local sizes and declarations
  // ****************************************************
  localparam int THR_W = $clog2(DEPTH);
  localparam int FCW = $clog2(DEPTH+1);
  localparam int CNT_W = $clog2(DEPTH+2);
  localparam int NPOS = arfq_pkg::CODE_W - 1;

  // Run state and captured thresholds
  logic run_ff;
  logic [THR_W-1:0] thr_full_ff;
  logic [THR_W-1:0] thr_empty_ff;

  // Write path
  arfq_pkg::arfq_entry_s wr_entry;
  logic [arfq_pkg::CODE_W-1:0] wr_code;
  logic fifo_wr_ready;
  logic s_fire;

  // Read path
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [arfq_pkg::CODE_W-1:0] rd_code;
  logic [FCW-1:0] fifo_count;
  arfq_pkg::arfq_dec_s rd_dec;
  logic load;
  logic m_fire;
  logic bypass;
  logic [arfq_pkg::CODE_W-1:0] dec_code;

  // Output stage
  logic m_valid_ff;
  arfq_pkg::arfq_entry_s m_entry_ff;
  logic sbit_ff;
  logic dbit_ff;

  // Occupancy and flags
  logic [CNT_W-1:0] total_ff;
  logic [CNT_W-1:0] nxt_total;
  logic prog_full_ff;
  logic prog_empty_ff;
  logic rejected_ff;
  logic nxt_rejected;

  // ****************************************************
  // Codeword builder
  // ****************************************************
  // Hamming code with an overall parity bit in position zero
  function automatic logic [arfq_pkg::CODE_W-1:0] ecc_encode(
    input logic [arfq_pkg::ENTRY_W-1:0] data
  );
    logic [arfq_pkg::CODE_W-1:0] code;
    int j;
    code = '0;
    j = 0;
    // Spread data over the non power of two positions
    for (int p = 1; p <= NPOS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        code[p] = data[j];
        j = j + 1;
      end
    end
    // Check bits at the power of two positions
    for (int i = 0; i < arfq_pkg::PAR_W; i++)
    begin
      for (int p = 1; p <= NPOS; p++)
      begin
        if ((((p >> i) & 1) == 1) && (p != (1 << i)))
        begin
          code[1 << i] = code[1 << i] ^ code[p];
        end
      end
    end
    code[0] = ^code[NPOS:1];
    ecc_encode = code;
  endfunction : ecc_encode

  // ****************************************************
  // Reset and thresholds
  // ****************************************************
  // Hold ready low through reset and the first cycle after it
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      run_ff <= arfq_pkg::RST_RUN;
    end
    else
    begin
      run_ff <= 1'h1;
    end
  end

  // Thresholds follow the pins while reset is held
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      thr_full_ff <= AR_FULL_THRESHOLD_IN;
      thr_empty_ff <= AR_EMPTY_THRESHOLD_IN;
    end
  end

  // ****************************************************
  // Write side
  // ****************************************************
  // Pack the accepted address and protection into one entry
  assign wr_entry.addr = S_AXI_ARADDR_IN;
  assign wr_entry.prot = S_AXI_ARPROT_IN;

  // Ready only while storage has room, so a full FIFO takes nothing
  assign S_AXI_ARREADY_OUT = fifo_wr_ready & run_ff;
  assign s_fire = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;

  // An empty FIFO hands a new entry straight to a free output stage, so valid
  // rises at the accepting edge instead of one cycle later
  assign bypass = s_fire & !fifo_rd_valid & fifo_rd_ready;

  // Encode, then flip chosen bits when injection is asked for
  always_comb
  begin
    wr_code = ecc_encode(wr_entry);
    if (ECC_EN && AR_INJECT_SINGLE_ERROR_IN && !AR_INJECT_DOUBLE_ERROR_IN)
    begin
      wr_code[arfq_pkg::INJ_POS_A] = ~wr_code[arfq_pkg::INJ_POS_A];
    end
    if (ECC_EN && AR_INJECT_DOUBLE_ERROR_IN)
    begin
      wr_code[arfq_pkg::INJ_POS_A] = ~wr_code[arfq_pkg::INJ_POS_A];
      wr_code[arfq_pkg::INJ_POS_B] = ~wr_code[arfq_pkg::INJ_POS_B];
    end
  end

  // ****************************************************
  // Storage
  // ****************************************************
  // Codewords wait here between the two handshakes
  arfq_fifo #(
    .WIDTH(arfq_pkg::CODE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_in(CLK_IN),
    .rst_n_in(RESETN_IN),
    .wr_valid_in(S_AXI_ARVALID_IN & run_ff & !bypass),
    .wr_ready_out(fifo_wr_ready),
    .wr_data_in(wr_code),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_rd_ready),
    .rd_data_out(rd_code),
    .count_out(fifo_count)
  );

  // Check and correct the oldest codeword, or the incoming one on a bypass
  assign dec_code = fifo_rd_valid ? rd_code : wr_code;
  arfq_ecc_dec u_dec (
    .code_in(dec_code),
    .dec_out(rd_dec)
  );

  // ****************************************************
  // Read side
  // ****************************************************
  // Refill the output stage when it is empty or being taken
  assign fifo_rd_ready = !m_valid_ff || M_AXI_ARREADY_IN;
  assign load = (fifo_rd_valid & fifo_rd_ready) | bypass;
  assign m_fire = m_valid_ff & M_AXI_ARREADY_IN;

  // Output valid rises with an entry and stays until accepted
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      m_valid_ff <= arfq_pkg::RST_FLAG;
    end
    else if (load)
    begin
      m_valid_ff <= 1'h1;
    end
    else if (m_fire)
    begin
      m_valid_ff <= 1'h0;
    end
  end

  // Entry and its error flags change only on a load
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      m_entry_ff <= '0;
      sbit_ff <= arfq_pkg::RST_FLAG;
      dbit_ff <= arfq_pkg::RST_FLAG;
    end
    else if (load)
    begin
      m_entry_ff <= rd_dec.entry;
      sbit_ff <= ECC_EN & rd_dec.single_err;
      dbit_ff <= ECC_EN & rd_dec.double_err;
    end
  end

  // Drive the master side from the output stage
  assign M_AXI_ARVALID_OUT = m_valid_ff;
  assign M_AXI_ARADDR_OUT = m_entry_ff.addr;
  assign M_AXI_ARPROT_OUT = m_entry_ff.prot;
  assign AR_SINGLE_ERROR_FLAG_OUT = sbit_ff & m_valid_ff;
  assign AR_DOUBLE_ERROR_FLAG_OUT = dbit_ff & m_valid_ff;

  // ****************************************************
  // Occupancy and programmable flags
  // ****************************************************
  // Words held anywhere in the block after this edge
  always_comb
  begin
    nxt_total = total_ff;
    if (s_fire && !m_fire)
    begin
      nxt_total = total_ff + CNT_W'(1);
    end
    else if (m_fire && !s_fire)
    begin
      nxt_total = total_ff - CNT_W'(1);
    end
  end

  // Count register
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      total_ff <= '0;
    end
    else
    begin
      total_ff <= nxt_total;
    end
  end

  // Compare the coming count against the captured thresholds
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      prog_full_ff <= arfq_pkg::RST_FLAG;
      prog_empty_ff <= 1'h1;
    end
    else
    begin
      prog_full_ff <= (nxt_total >= CNT_W'(thr_full_ff));
      prog_empty_ff <= (nxt_total <= CNT_W'(thr_empty_ff));
    end
  end

  assign AR_PROG_FULL_OUT = prog_full_ff;
  assign AR_PROG_EMPTY_OUT = prog_empty_ff;

  // ****************************************************
  // Rejected write indication
  // ****************************************************
  // A request seen while full is refused and reported next cycle
  assign nxt_rejected = S_AXI_ARVALID_IN & run_ff & !fifo_wr_ready;

  // One pulse per refused cycle; storage is untouched
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      rejected_ff <= arfq_pkg::RST_FLAG;
    end
    else
    begin
      rejected_ff <= nxt_rejected;
    end
  end

  assign AR_WRITE_REJECTED_FLAG_OUT = rejected_ff;

  // Unused count bits are only observed for width checks
  logic unused_count;
  assign unused_count = ^fifo_count;
endmodule : arfq_top
`default_nettype wire

//--- verification/arfq_top_sva.sv
// Concurrent checks on the read-address channel FIFO ports
`default_nettype none
// ****************************************************
// Port checker
// ****************************************************
module arfq_top_sva #(
  parameter int DEPTH = 8
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic [arfq_pkg::ADDR_W-1:0] M_AXI_ARADDR_OUT,
  input wire logic [arfq_pkg::PROT_W-1:0] M_AXI_ARPROT_OUT,
  input wire logic M_AXI_ARVALID_OUT,
  input wire logic M_AXI_ARREADY_IN,
  input wire logic [$clog2(DEPTH)-1:0] AR_FULL_THRESHOLD_IN,
  input wire logic [$clog2(DEPTH)-1:0] AR_EMPTY_THRESHOLD_IN,
  input wire logic AR_SINGLE_ERROR_FLAG_OUT,
  input wire logic AR_DOUBLE_ERROR_FLAG_OUT,
  input wire logic AR_WRITE_REJECTED_FLAG_OUT,
  input wire logic AR_PROG_FULL_OUT,
  input wire logic AR_PROG_EMPTY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] FULL_CNT = 4'(DEPTH + 1);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [$clog2(DEPTH)-1:0] full_thr_ff;
  logic [$clog2(DEPTH)-1:0] empty_thr_ff;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // Words held, followed from both handshakes
  always_comb nxt_cnt = cnt_ff + 4'(S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
                        - 4'(M_AXI_ARVALID_OUT && M_AXI_ARREADY_IN);
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end
  // Thresholds as captured while reset is low
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      full_thr_ff <= AR_FULL_THRESHOLD_IN;
      empty_thr_ff <= AR_EMPTY_THRESHOLD_IN;
    end
  end
  a_full_refuse: assert property (cnt_ff == FULL_CNT |-> !S_AXI_ARREADY_OUT)
    else $error("ready high while full");
  a_ready_free: assert property (RESETN_IN && $past(RESETN_IN) && $past(RESETN_IN, 2)
    && cnt_ff < FULL_CNT |-> S_AXI_ARREADY_OUT)
    else $error("ready low with room");
  a_valid_count: assert property (M_AXI_ARVALID_OUT == (cnt_ff != 4'h0))
    else $error("master valid disagrees with count");
  a_hold_offer: assert property (M_AXI_ARVALID_OUT && !M_AXI_ARREADY_IN |=> M_AXI_ARVALID_OUT
    && $stable(M_AXI_ARADDR_OUT) && $stable(M_AXI_ARPROT_OUT))
    else $error("offer changed before accept");
  a_reject_pulse: assert property (S_AXI_ARVALID_IN && cnt_ff == FULL_CNT
    |=> AR_WRITE_REJECTED_FLAG_OUT)
    else $error("refused write not flagged");
  a_reject_cause: assert property (AR_WRITE_REJECTED_FLAG_OUT
    |-> $past(S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT))
    else $error("rejected flag without refusal");
  a_prog_full: assert property (AR_PROG_FULL_OUT == (cnt_ff >= full_thr_ff))
    else $error("full flag wrong");
  a_prog_empty: assert property (AR_PROG_EMPTY_OUT == (cnt_ff <= empty_thr_ff))
    else $error("empty flag wrong");
  a_err_flags: assert property (AR_SINGLE_ERROR_FLAG_OUT || AR_DOUBLE_ERROR_FLAG_OUT
    |-> M_AXI_ARVALID_OUT && !(AR_SINGLE_ERROR_FLAG_OUT && AR_DOUBLE_ERROR_FLAG_OUT))
    else $error("error flag without entry");
endmodule : arfq_top_sva
bind arfq_top arfq_top_sva #(.DEPTH(DEPTH)) arfq_top_sva_inst (.CLK_IN(CLK_IN),
  .RESETN_IN(RESETN_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .M_AXI_ARADDR_OUT(M_AXI_ARADDR_OUT),
  .M_AXI_ARPROT_OUT(M_AXI_ARPROT_OUT), .M_AXI_ARVALID_OUT(M_AXI_ARVALID_OUT),
  .M_AXI_ARREADY_IN(M_AXI_ARREADY_IN), .AR_FULL_THRESHOLD_IN(AR_FULL_THRESHOLD_IN),
  .AR_EMPTY_THRESHOLD_IN(AR_EMPTY_THRESHOLD_IN),
  .AR_SINGLE_ERROR_FLAG_OUT(AR_SINGLE_ERROR_FLAG_OUT),
  .AR_DOUBLE_ERROR_FLAG_OUT(AR_DOUBLE_ERROR_FLAG_OUT),
  .AR_WRITE_REJECTED_FLAG_OUT(AR_WRITE_REJECTED_FLAG_OUT),
  .AR_PROG_FULL_OUT(AR_PROG_FULL_OUT), .AR_PROG_EMPTY_OUT(AR_PROG_EMPTY_OUT));
`default_nettype wire

//--- verification/arfq_slave_model.sv
// Downstream slave model that takes buffered read addresses
`default_nettype none
// ****************************************************
// Downstream slave
// ****************************************************
module arfq_slave_model (
  // Clock and pacing, 0 ready, 1 every other cycle, 2 stalled
  input wire logic clk_in,
  input wire logic [1:0] mode_in,
  // Offered entry
  input wire logic valid_in,
  input wire logic [arfq_pkg::ADDR_W-1:0] addr_in,
  input wire logic [arfq_pkg::PROT_W-1:0] prot_in,
  input wire logic single_in,
  input wire logic double_in,
  // Acceptance
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [37:0] got_q[$];
  logic phase = 1'h0;
  initial ready_out = 1'h0;
  // Record each accepted entry, then set ready for the next cycle
  always @(posedge clk_in)
  begin
    if (valid_in === 1'h1 && ready_out === 1'h1)
      got_q.push_back({addr_in, prot_in, single_in, double_in});
    #2;
    phase = !phase;
    ready_out = (mode_in == 2'h0) || (mode_in == 2'h1 && phase);
  end
endmodule : arfq_slave_model
`default_nettype wire

//--- verification/arfq_top_tb.sv
// Self-checking bench for the read-address channel FIFO
`default_nettype none
// ****************************************************
// Bench top
// ****************************************************
module arfq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] prot;
    logic [1:0] inj;
    logic [1:0] flg;
  } arfq_row_s;
  logic clk = 1'h0;
  logic rstn, s_valid, s_ready, m_valid, m_ready, inj_s, inj_d;
  logic f_single, f_double, f_rej, f_full, f_empty;
  logic [31:0] s_addr, m_addr;
  logic [3:0] s_prot, m_prot;
  logic [2:0] full_thr, empty_thr;
  logic [1:0] mode;
  logic [37:0] got;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  arfq_row_s rows [6] = '{'{32'h00000000, 4'h0, 2'h0, 2'h0}, '{32'hFFFFFFFF, 4'hF, 2'h0, 2'h0},
    '{32'h12345678, 4'h5, 2'h2, 2'h2}, '{32'hA5A55A5A, 4'hA, 2'h1, 2'h1},
    '{32'h80000001, 4'h3, 2'h3, 2'h1}, '{32'h7FFFFFFE, 4'hC, 2'h0, 2'h0}};
  arfq_top arfq_top_inst (.CLK_IN(clk), .RESETN_IN(rstn), .S_AXI_ARADDR_IN(s_addr),
    .S_AXI_ARPROT_IN(s_prot), .S_AXI_ARVALID_IN(s_valid), .S_AXI_ARREADY_OUT(s_ready),
    .M_AXI_ARADDR_OUT(m_addr), .M_AXI_ARPROT_OUT(m_prot), .M_AXI_ARVALID_OUT(m_valid),
    .M_AXI_ARREADY_IN(m_ready), .AR_FULL_THRESHOLD_IN(full_thr),
    .AR_EMPTY_THRESHOLD_IN(empty_thr), .AR_INJECT_SINGLE_ERROR_IN(inj_s),
    .AR_INJECT_DOUBLE_ERROR_IN(inj_d), .AR_SINGLE_ERROR_FLAG_OUT(f_single),
    .AR_DOUBLE_ERROR_FLAG_OUT(f_double), .AR_WRITE_REJECTED_FLAG_OUT(f_rej),
    .AR_PROG_FULL_OUT(f_full), .AR_PROG_EMPTY_OUT(f_empty));
  arfq_slave_model arfq_slave_model_inst (.clk_in(clk), .mode_in(mode), .valid_in(m_valid),
    .addr_in(m_addr), .prot_in(m_prot), .single_in(f_single), .double_in(f_double),
    .ready_out(m_ready));
  // Clock and cycle ceiling
  always #4 clk = !clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [37:0] seen, input logic [37:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // Present one entry after an edge and hold it until taken
  task automatic offer(input arfq_row_s r);
    int n;
    n = 0;
    s_valid = 1'h1;
    s_addr = r.addr;
    s_prot = r.prot;
    {inj_s, inj_d} = r.inj;
    while (s_ready !== 1'h1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
  endtask : offer
  task automatic idle_drain();
    int n;
    n = 0;
    s_valid = 1'h0;
    {inj_s, inj_d} = 2'h0;
    while (m_valid !== 1'h0 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : idle_drain
  task automatic expect_fill(input int k);
    for (int i = 0; i < k; i++)
    begin
      got = arfq_slave_model_inst.got_q.pop_front();
      chk("fill entry", got, {32'h10000000 + 32'(i), 4'(i), 2'h0});
    end
  endtask : expect_fill
  initial
  begin
    {rstn, s_valid, inj_s, inj_d, s_addr, s_prot, mode} = '0;
    full_thr = 3'h6;
    empty_thr = 3'h2;
    repeat (4) @(posedge clk);
    #1;
    chk("reset outs", {s_ready, m_valid, f_single, f_double, f_rej, f_full, f_empty}, 38'h1);
    rstn = 1'h1;
    // Table rows, partner always ready
    foreach (rows[i]) offer(rows[i]);
    idle_drain();
    foreach (rows[i])
    begin
      got = arfq_slave_model_inst.got_q.pop_front();
      if (rows[i].flg[0])
        chk("double flag", got[1:0], rows[i].flg);
      else
        chk("entry", got, {rows[i].addr, rows[i].prot, rows[i].flg});
    end
    // Fill against a stalled partner, then refuse a tenth
    mode = 2'h2;
    for (int i = 0; i < 10; i++) offer({32'h10000000 + 32'(i), 4'(i), 4'h0});
    chk("full flags", {s_ready, f_rej, f_full, f_empty}, 38'h6);
    mode = 2'h1;
    offer({32'h10000009, 4'h9, 4'h0});
    idle_drain();
    expect_fill(10);
    chk("drained", {m_valid, f_full, f_empty}, 38'h1);
    // Second reset with new thresholds, full boundary at three words
    rstn = 1'h0;
    full_thr = 3'h3;
    empty_thr = 3'h0;
    mode = 2'h2;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'h1;
    for (int i = 0; i < 2; i++) offer({32'h10000000 + 32'(i), 4'(i), 4'h0});
    chk("two held", {f_full, f_empty}, 38'h0);
    offer({32'h10000002, 4'h2, 4'h0});
    chk("three held", {f_full, f_empty}, 38'h2);
    mode = 2'h0;
    idle_drain();
    expect_fill(3);
    report_and_stop();
  end
endmodule : arfq_top_tb
`default_nettype wire
